// [i2c_pkg.sv]
package i2c_pkg;
   // ==========================================================
   // Link constants.
   localparam logic [4:0] ADDR_FIXED     = 5'h13;   // Upper five address bits, 10011.
   localparam logic [7:0] PAGE_REG_OFF   = 8'h00;   // Page selector offset.
   localparam logic [7:0] BOOK_REG_OFF   = 8'h7F;   // Book selector offset on page zero.
   localparam logic [7:0] PAGE_RESET     = 8'h00;   // Page selector reset value.
   localparam int         CLK_FREQ_KHZ   = 250000;  // System clock rate.
   localparam int         SCL_STD_KHZ    = 100;     // Standard-mode bit rate.
   localparam int         SCL_FAST_KHZ   = 400;     // Fast-mode bit rate.
   localparam int         QTR_STD        = CLK_FREQ_KHZ / (SCL_STD_KHZ * 4);
   localparam int         QTR_FAST       = CLK_FREQ_KHZ / (SCL_FAST_KHZ * 4);
   // ==========================================================
   // Host register map, byte addresses on AHB-Lite.
   localparam logic [7:0] REG_CTRL       = 8'h00;   // W: go, rw, fast, dev, len.
   localparam logic [7:0] REG_SUBADDR    = 8'h04;   // Subaddress byte.
   localparam logic [7:0] REG_WDATA      = 8'h08;   // Write byte, one per data cycle.
   localparam logic [7:0] REG_RDATA      = 8'h0C;   // Last read byte.
   localparam logic [7:0] REG_STATUS     = 8'h10;   // Busy, nack.
   localparam int         CTRL_GO        = 0;
   localparam int         CTRL_RD        = 1;
   localparam int         CTRL_FAST      = 2;
   localparam int         CTRL_DEV_LSB   = 4;       // Two strap bits of target address.
   localparam int         CTRL_LEN_LSB   = 8;       // Byte count, one to 255.
   localparam int         STAT_BUSY      = 0;
   localparam int         STAT_NACK      = 1;
endpackage

// [i2c_link_if.sv]
interface i2c_link_if;
   logic scl_o;    // Clock driven by controller.
   logic scl_oe;   // Controller drives clock low when high.
   logic sda_c_oe; // Controller pulls data low.
   logic sda_d_oe; // Device pulls data low.
   logic scl;      // Resolved clock level.
   logic sda;      // Resolved data level.
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~(sda_c_oe | sda_d_oe);
   modport ctrl (output scl_o, output scl_oe, output sda_c_oe, input scl, input sda);
   modport dev  (output sda_d_oe, input scl, input sda);
endinterface

// [i2c_dev_end.sv]
// Overview of operation
// - Peripheral at 100 and 400 kHz, multi-byte.
// - Offset zero holds page pointer, 256 pages; link reads there return rd_data, not page_sel.
// - Controller sets page before accessing locations.
// - Control registers live on page zero.
// - Seven-bit address, upper bits 10011.
// - Strap gives two low address bits.
// - Acknowledge write address only on match.
// - Subaddress then data, each acknowledged, stored.
// - Controller stops after last written byte.
// - Subaddress increments after each written byte.
// - Read uses subaddress write, repeated start.
// - Drive byte at supplied subaddress after ack.
// - Controller nacks then stops single read.
// - Multi read: ack all but last, increment.
// - Offset 7F on page zero holds book.
module i2c_dev_end
   import i2c_pkg::*;
(
   input  wire logic       hclk,      // System clock.
   input  wire logic       hresetn,   // Asynchronous reset, active low.
   input  wire logic       clk_en,    // Freezes all state while low.
   input  wire logic [1:0] strap,     // Decoded address strap level.
   i2c_link_if.dev         link,      // Serial link.
   output logic [7:0]      page_sel,  // Current page selector.
   output logic [7:0]      book_sel,  // Current book selector.
   output logic            wr_stb,    // One-cycle pulse per stored byte.
   output logic [7:0]      wr_addr,   // Location of stored byte.
   output logic [7:0]      wr_data,   // Stored byte.
   output logic [7:0]      rd_addr,   // Location the link is reading.
   input  wire logic [7:0] rd_data    // Byte at rd_addr on current page.
);
   import i2c_pkg::*;

   // Frame states: address, subaddress, write data, read send, read acknowledge.
   typedef enum {S_IDLE, S_ADDR, S_SUB, S_DATA, S_SEND, S_MACK} st_e;

   // Engine state, synchroniser stages and captured bytes.
   st_e        st_reg;
   logic [1:0] scl_s_reg;
   logic [1:0] sda_s_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic [7:0] sub_reg;
   logic       ack_reg;
   logic       rd_dir_reg;
   logic [1:0] strap_s_reg;
   logic [1:0] strap_reg;
   logic [7:0] page_reg;
   logic [7:0] book_reg;

   // ==========================================================
   // Pin synchronisers and edge detection.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_s_reg <= 2'h3;
         sda_s_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else if (clk_en) begin
         scl_s_reg <= {scl_s_reg[0], link.scl};
         sda_s_reg <= {sda_s_reg[0], link.sda};
         scl_d_reg <= scl_s_reg[1];
         sda_d_reg <= sda_s_reg[1];
      end
   end

   // Synchronised levels, clock edges and start and stop conditions.
   wire scl_now = scl_s_reg[1];
   wire sda_now = sda_s_reg[1];
   wire scl_rise = scl_now & ~scl_d_reg;
   wire scl_fall = ~scl_now & scl_d_reg;
   wire start_c = scl_now & scl_d_reg & sda_d_reg & ~sda_now;
   wire stop_c  = scl_now & scl_d_reg & ~sda_d_reg & sda_now;
   wire [7:0] byte_in = {sh_reg[6:0], sda_now};

   // Strap pin passes two flip-flops before the address compare reads it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_s_reg <= 2'h0;
         strap_reg   <= 2'h0;
      end else if (clk_en) begin
         strap_s_reg <= strap;
         strap_reg   <= strap_s_reg;
      end
   end

   // ==========================================================
   // Byte engine: bits taken on SCL rise, data changed on SCL fall.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg     <= S_IDLE;
         bit_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         sub_reg    <= 8'h00;
         ack_reg    <= 1'b0;
         rd_dir_reg <= 1'b0;
      end else if (clk_en) begin
         if (start_c) begin
            st_reg  <= S_ADDR;
            bit_reg <= 4'h0;
            ack_reg <= 1'b0;
         end else if (stop_c) begin
            st_reg  <= S_IDLE;
            ack_reg <= 1'b0;
         end else begin
            case (st_reg)
               S_IDLE: ;
               S_ADDR, S_SUB, S_DATA: begin
                  if (scl_rise && bit_reg < 4'h8) begin
                     sh_reg  <= byte_in;
                     bit_reg <= bit_reg + 4'h1;
                  end else if (scl_fall && bit_reg == 4'h8) begin
                     bit_reg <= 4'h9;
                     if (st_reg == S_ADDR) begin
                        // Match on fixed bits and strap bits.
                        if (sh_reg[7:1] == {ADDR_FIXED, strap_reg}) begin
                           ack_reg    <= 1'b1;
                           rd_dir_reg <= sh_reg[0];
                        end else begin
                           st_reg <= S_IDLE;
                        end
                     end else begin
                        ack_reg <= 1'b1;
                     end
                  end else if (scl_fall && bit_reg == 4'h9) begin
                     ack_reg <= 1'b0;
                     bit_reg <= 4'h0;
                     case (st_reg)
                        S_ADDR: begin
                           if (rd_dir_reg) begin
                              st_reg <= S_SEND;
                              sh_reg <= rd_data;
                           end else begin
                              st_reg <= S_SUB;
                           end
                        end
                        S_SUB: begin
                           sub_reg <= sh_reg;
                           st_reg  <= S_DATA;
                        end
                        default: begin
                           sub_reg <= sub_reg + 8'h01;
                        end
                     endcase
                  end
               end
               S_SEND: begin
                  if (scl_fall && bit_reg < 4'h7) begin
                     sh_reg  <= {sh_reg[6:0], 1'b0};
                     bit_reg <= bit_reg + 4'h1;
                  end else if (scl_fall && bit_reg == 4'h7) begin
                     st_reg  <= S_MACK;
                     bit_reg <= 4'h0;
                  end
               end
               S_MACK: begin
                  if (scl_rise) begin
                     sub_reg <= sub_reg + 8'h01;
                     if (sda_now) st_reg <= S_IDLE;
                  end else if (scl_fall) begin
                     st_reg <= S_SEND;
                     sh_reg <= rd_data;
                  end
               end
               default: st_reg <= S_IDLE;
            endcase
         end
      end
   end

   // A data byte is stored on the clock fall that ends its eighth bit.
   wire store = clk_en && !start_c && !stop_c && st_reg == S_DATA
                && scl_fall && bit_reg == 4'h8;

   // ==========================================================
   // Write strobe and page and book selectors.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         page_reg <= PAGE_RESET;
         book_reg <= 8'h00;
         wr_stb   <= 1'b0;
         wr_addr  <= 8'h00;
         wr_data  <= 8'h00;
      end else if (clk_en) begin
         wr_stb <= store;
         if (store) begin
            wr_addr <= sub_reg;
            wr_data <= sh_reg;
            if (sub_reg == PAGE_REG_OFF) page_reg <= sh_reg;
            if (sub_reg == BOOK_REG_OFF && page_reg == 8'h00) book_reg <= sh_reg;
         end
      end
   end

   // Reads at every offset, zero included, return rd_data from the user port; page_sel is not read back.
   assign rd_addr  = sub_reg;
   assign page_sel = page_reg;
   assign book_sel = book_reg;
   // Pull low for acknowledge, or for a zero read bit in S_SEND.
   assign link.sda_d_oe = ack_reg | (st_reg == S_SEND && !sh_reg[7]);
endmodule

// [i2c_ctrl_end.sv]
module i2c_ctrl_end
   import i2c_pkg::*;
(
   input  wire logic        hclk,       // System clock.
   input  wire logic        hresetn,    // Asynchronous reset, active low.
   input  wire logic        clk_en,     // Freezes all state while low.
   input  wire logic        hsel,       // AHB slave select.
   input  wire logic [31:0] haddr,      // AHB address.
   input  wire logic [1:0]  htrans,     // AHB transfer type.
   input  wire logic        hwrite,     // AHB direction.
   input  wire logic [2:0]  hsize,      // AHB size.
   input  wire logic [31:0] hwdata,     // AHB write data.
   input  wire logic        hready,     // AHB bus ready.
   output logic [31:0]      hrdata,     // AHB read data.
   output logic             hreadyout,  // Slave ready.
   output logic             hresp,      // Always OKAY.
   i2c_link_if.ctrl         link        // Serial link.
);
   import i2c_pkg::*;

   typedef enum {C_IDLE, C_START, C_BIT, C_ACK, C_STOP} cst_e;

   logic        ph_reg, ph_wr_reg;
   logic [7:0]  ph_a_reg;
   logic        go_reg, rd_reg, fast_reg;
   logic [1:0]  dev_reg;
   logic [7:0]  len_reg, sub_reg, wdat_reg, rdat_reg;
   logic        wvalid_reg, nack_reg;
   cst_e        cs_reg;
   logic [15:0] qcnt_reg;
   logic [1:0]  q_reg;
   logic [3:0]  bit_reg;
   logic [2:0]  phase_reg;  // 0 addr-w,1 sub,2 data,3 addr-r,4 rdata.
   logic [7:0]  sh_reg;
   logic [7:0]  left_reg;
   logic        scl_reg, sda_oe_reg;
   logic [1:0]  sda_s_reg;

   // ==========================================================
   // AHB-Lite slave, zero wait states except for a WDATA write while the previous byte is pending.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_reg <= 1'b0; ph_wr_reg <= 1'b0; ph_a_reg <= 8'h00;
      end else if (clk_en && hready) begin
         ph_reg    <= hsel & htrans[1];
         ph_wr_reg <= hwrite;
         ph_a_reg  <= haddr[7:0];
      end
   end
   wire wr_now = clk_en & ph_reg & ph_wr_reg;
   wire busy = cs_reg != C_IDLE;
   wire take_byte = cs_reg == C_BIT && bit_reg == 4'h0 && q_reg == 2'h0 && qcnt_reg == 16'h0
                    && phase_reg == 3'h2;

   always_comb begin
      case (ph_a_reg)
         REG_SUBADDR: hrdata = {24'h0, sub_reg};
         REG_RDATA:   hrdata = {24'h0, rdat_reg};
         REG_STATUS:  hrdata = {30'h0, nack_reg, busy};
         default:     hrdata = 32'h0;
      endcase
   end
   // A write byte is held off with wait states while the previous one is still pending.
   assign hreadyout = !(ph_reg && ph_wr_reg && ph_a_reg == REG_WDATA && wvalid_reg);
   assign hresp = 1'b0;

   // ==========================================================
   // Serial engine: four quarter steps per bit.
   wire [15:0] qlen = fast_reg ? 16'(QTR_FAST - 1) : 16'(QTR_STD - 1);
   wire tick = clk_en && qcnt_reg == 16'h0;
   wire sda_in = sda_s_reg[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sda_s_reg <= 2'h3;
      else if (clk_en) sda_s_reg <= {sda_s_reg[0], link.sda};
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         go_reg <= 1'b0; rd_reg <= 1'b0; fast_reg <= 1'b0; dev_reg <= 2'h0;
         len_reg <= 8'h01; sub_reg <= 8'h00; wdat_reg <= 8'h00; wvalid_reg <= 1'b0;
      end else if (clk_en) begin
         if (take_byte && tick) wvalid_reg <= 1'b0;
         if (wr_now && ph_a_reg == REG_CTRL && !busy) begin
            go_reg   <= hwdata[CTRL_GO];
            rd_reg   <= hwdata[CTRL_RD];
            fast_reg <= hwdata[CTRL_FAST];
            dev_reg  <= hwdata[CTRL_DEV_LSB +: 2];
            len_reg  <= hwdata[CTRL_LEN_LSB +: 8];
         end else go_reg <= 1'b0;
         if (wr_now && ph_a_reg == REG_SUBADDR) sub_reg <= hwdata[7:0];
         if (wr_now && ph_a_reg == REG_WDATA && !wvalid_reg) begin
            wdat_reg <= hwdata[7:0]; wvalid_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_reg <= C_IDLE; qcnt_reg <= 16'h0; q_reg <= 2'h0; bit_reg <= 4'h0;
         phase_reg <= 3'h0; sh_reg <= 8'h00; left_reg <= 8'h00; scl_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
         nack_reg   <= 1'b0;
         rdat_reg   <= 8'h00;
      end else if (clk_en) begin
         qcnt_reg <= (qcnt_reg == 16'h0) ? qlen : qcnt_reg - 16'h1;
         case (cs_reg)
            C_IDLE: begin
               scl_reg    <= 1'b1;
               sda_oe_reg <= 1'b0;
               if (go_reg) begin
                  cs_reg <= C_START; q_reg <= 2'h0; qcnt_reg <= qlen;
                  nack_reg <= 1'b0; left_reg <= len_reg;
                  phase_reg <= 3'h0; sh_reg <= {ADDR_FIXED, dev_reg, 1'b0};
               end
            end
            C_START: if (tick) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  2'h0: begin scl_reg <= 1'b1; sda_oe_reg <= 1'b0; end
                  2'h1: sda_oe_reg <= 1'b1;
                  2'h2: scl_reg <= 1'b0;
                  default: begin cs_reg <= C_BIT; bit_reg <= 4'h0; end
               endcase
            end
            C_BIT: if (tick && !(phase_reg == 3'h2 && !wvalid_reg && q_reg == 2'h0
                                 && bit_reg == 4'h0)) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  2'h0: begin
                     if (bit_reg == 4'h0 && phase_reg == 3'h2) begin
                        sh_reg <= {wdat_reg[6:0], 1'b0}; sda_oe_reg <= !wdat_reg[7];
                     end else begin
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        sda_oe_reg <= (phase_reg == 3'h4) ? 1'b0 : !sh_reg[7];
                     end
                  end
                  2'h1: scl_reg <= 1'b1;
                  2'h2: if (phase_reg == 3'h4) rdat_reg <= {rdat_reg[6:0], sda_in};
                  default: begin
                     scl_reg <= 1'b0;
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'h7) cs_reg <= C_ACK;
                  end
               endcase
            end
            C_ACK: if (tick) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  // Controller answers read bytes, ack all but last.
                  2'h0: sda_oe_reg <= (phase_reg == 3'h4) && left_reg != 8'h01;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: if (phase_reg != 3'h4 && sda_in) nack_reg <= 1'b1;
                  default: begin
                     scl_reg <= 1'b0; bit_reg <= 4'h0; cs_reg <= C_BIT;
                     if (nack_reg) cs_reg <= C_STOP;
                     else case (phase_reg)
                        3'h0: begin phase_reg <= 3'h1; sh_reg <= sub_reg; end
                        3'h1: if (rd_reg) begin
                           phase_reg <= 3'h3;
                           cs_reg    <= C_START;
                           sh_reg <= {ADDR_FIXED, dev_reg, 1'b1};
                        end else phase_reg <= 3'h2;
                        3'h3: phase_reg <= 3'h4;
                        default: begin
                           left_reg <= left_reg - 8'h01;
                           if (left_reg == 8'h01) cs_reg <= C_STOP;
                        end
                     endcase
                  end
               endcase
            end
            C_STOP: if (tick) begin
               q_reg <= q_reg + 2'h1;
               case (q_reg)
                  2'h0: sda_oe_reg <= 1'b1;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: sda_oe_reg <= 1'b0;
                  default: cs_reg <= C_IDLE;
               endcase
            end
            default: cs_reg <= C_IDLE;
         endcase
      end
   end

   assign link.scl_o    = scl_reg;
   assign link.scl_oe   = ~scl_reg; // Open drain: the clock is only ever pulled low.
   assign link.sda_c_oe = sda_oe_reg;
endmodule

// [i2c_link_monitor.sv]
module i2c_link_monitor
   import i2c_pkg::*;
(
   input wire logic hclk,      // System clock.
   input wire logic hresetn,   // Asynchronous reset, active low.
   input wire logic scl_o,     // Controller clock level.
   input wire logic scl_oe,    // Controller clock enable.
   input wire logic sda_c_oe,  // Controller pulls data low.
   input wire logic sda_d_oe,  // Device pulls data low.
   input wire logic scl,       // Resolved clock level.
   input wire logic sda        // Resolved data level.
);
   localparam int HI_MIN = QTR_FAST / 2;
   logic        scl_q, sda_q, first_q, rd_q, ack_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;
   logic [15:0] hi_q;
   logic        scl_rise, scl_fall, start_det, stop_det, ack_rise, dat_rise;
   // ==========================================================
   // Edge and bus condition decode on the resolved lines.
   assign scl_rise  = scl & ~scl_q;
   assign scl_fall  = ~scl & scl_q;
   assign start_det = scl & scl_q & sda_q & ~sda;
   assign stop_det  = scl & scl_q & ~sda_q & sda;
   assign ack_rise  = scl_rise & (bit_q == 4'h8);
   assign dat_rise  = scl_rise & (bit_q != 4'h0) & (bit_q < 4'h8);
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // One-cycle history of both lines.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // Bit position, direction and last acknowledge level of the frame.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_q   <= 4'h0;
         first_q <= 1'b0;
         rd_q    <= 1'b0;
         ack_q   <= 1'b0;
      end else if (start_det) begin
         bit_q   <= 4'h0;
         first_q <= 1'b1;
         rd_q    <= 1'b0;
      end else if (scl_rise) begin
         bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
         if (bit_q == 4'h8) begin
            ack_q   <= sda;
            first_q <= 1'b0;
            if (first_q) begin
               rd_q <= sh_q[0];
            end
         end
      end
   end
   // Shifts in each data bit, first bit sent lands in the top.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sh_q <= 8'h00;
      end else if (scl_rise && bit_q != 4'h8) begin
         sh_q <= {sh_q[6:0], sda};
      end
   end
   // Counts how long the clock has stayed high.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_q <= 16'h0000;
      end else if (!scl) begin
         hi_q <= 16'h0000;
      end else if (hi_q != 16'hFFFF) begin
         hi_q <= hi_q + 16'h0001;
      end
   end
   // ==========================================================
   // Wire checks.
   dev_data_hold_a: assert property (scl && scl_q |-> $stable(sda_d_oe))
      else $error("device moved data while clock high");
   clk_high_time_a: assert property (scl_fall |-> hi_q >= HI_MIN)
      else $error("clock high phase too short");
   addr_match_a: assert property (ack_rise && first_q && sda_d_oe |-> sh_q[7:3] == ADDR_FIXED)
      else $error("device acknowledged a foreign address");
   write_quiet_a: assert property (dat_rise && !rd_q |-> !sda_d_oe)
      else $error("device drove data bits of a write frame");
   write_ack_a: assert property (ack_rise && !first_q && !rd_q |-> sda_d_oe)
      else $error("device missed a write byte acknowledge");
   read_ack_free_a: assert property (ack_rise && !first_q && rd_q |-> !sda_d_oe)
      else $error("device held the controller acknowledge slot");
   read_quiet_a: assert property (dat_rise && rd_q |-> !sda_c_oe)
      else $error("controller drove data bits of a read frame");
   stop_place_a: assert property (stop_det |-> bit_q == 4'h1)
      else $error("stop outside a byte boundary");
   read_nack_a: assert property (stop_det && rd_q |-> ack_q)
      else $error("read frame ended without a not-acknowledge");
   cover property (start_det);
   cover property (stop_det && rd_q);
   cover property (ack_rise && first_q && !sda_d_oe);
endmodule

// [i2c_paged_control_port_tb_top.sv]
module i2c_paged_control_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import i2c_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wr_stb;
   logic [1:0]  htrans, strap;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd_word;
   logic [7:0]  page_sel, book_sel, wr_addr, wr_data, rd_addr, rd_data, pg, bk;
   int          fail_count = 0;
   int          checked = 0;
   logic [15:0] exp_q[$];
   i2c_link_if  link();
   // ==========================================================
   // Both ends and the wire checker.
   i2c_dev_end u_i2c_dev_end (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .strap(strap),
      .link(link), .page_sel(page_sel), .book_sel(book_sel), .wr_stb(wr_stb),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
   i2c_ctrl_end u_i2c_ctrl_end (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link(link));
   i2c_link_monitor u_i2c_link_monitor (.hclk(hclk), .hresetn(hresetn), .scl_o(link.scl_o),
      .scl_oe(link.scl_oe), .sda_c_oe(link.sda_c_oe), .sda_d_oe(link.sda_d_oe),
      .scl(link.scl), .sda(link.sda));
   // Memory behind the device: each location holds its offset scrambled.
   assign rd_data = rd_addr ^ 8'h5A;
   // Free-running system clock.
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   // ==========================================================
   // Shared tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One single word transfer; entered just after a rising edge.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Runs one link transfer in fast mode and leaves the final status in rd_word.
   task automatic run_op(input logic [7:0] sub, input logic rd, input logic [1:0] dev,
                         input logic [7:0] len, input logic [7:0] d0);
      logic [7:0] k;
      ahb(1'b1, REG_SUBADDR, {24'h000000, sub}, rd_word);
      ahb(1'b1, REG_CTRL, {16'h0000, len, 2'b00, dev, 1'b0, 1'b1, rd, 1'b1}, rd_word);
      for (k = 8'h00; !rd && k < len; k++) begin
         exp_q.push_back({sub + k, d0 + k});
         ahb(1'b1, REG_WDATA, {24'h000000, d0 + k}, rd_word);
      end
      do ahb(1'b0, REG_STATUS, 32'h0, rd_word); while (rd_word[STAT_BUSY] !== 1'b0);
   endtask
   // ==========================================================
   // Watches stored bytes and matches them against the oldest note.
   always @(posedge hclk) begin
      if (wr_stb === 1'b1) begin
         if (exp_q.size() == 0) begin
            check({16'h0000, wr_addr, wr_data}, 32'hFFFFFFFF);
         end else begin
            check({16'h0000, wr_addr, wr_data}, {16'h0000, exp_q.pop_front()});
         end
      end
   end
   // Cuts a hung run short; the four transfers need about 80000 cycles.
   initial begin
      repeat (95000) @(posedge hclk);
      fail_count++;
      stop_test();
   end
   // ==========================================================
   // Main sequence.
   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      void'($urandom(32'h2FAF));
      pg = 8'($urandom_range(1, 255));
      bk = 8'($urandom);
      strap <= 2'($urandom);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({24'h0, page_sel}, {24'h0, PAGE_RESET});
      // Two bytes from 7E on page zero: the second lands in the book selector.
      run_op(8'h7E, 1'b0, strap, 8'h02, bk - 8'h01);
      check({24'h0, book_sel}, {24'h0, bk});
      check({24'h0, page_sel}, {24'h0, PAGE_RESET});
      // Page pointer written at offset zero.
      run_op(PAGE_REG_OFF, 1'b0, strap, 8'h01, pg);
      check({24'h0, page_sel}, {24'h0, pg});
      // Two-byte read from FF wraps to 00; last byte is kept in RDATA.
      run_op(8'hFF, 1'b1, strap, 8'h02, 8'h00);
      check({31'h0, rd_word[STAT_NACK]}, 32'h0);
      ahb(1'b0, REG_RDATA, 32'h0, rd_word);
      check(rd_word, {24'h0, 8'h00 ^ 8'h5A});
      check({24'h0, page_sel}, {24'h0, pg});
      // Foreign strap bits: no acknowledge, nothing stored.
      run_op(8'h10, 1'b1, strap ^ 2'b01, 8'h01, 8'h00);
      check({31'h0, rd_word[STAT_NACK]}, 32'h1);
      check({31'h0, hresp}, 32'h0);
      repeat (20) @(posedge hclk);
      check(exp_q.size(), 32'h0);
      check({24'h0, page_sel}, {24'h0, pg});
      stop_test();
   end
endmodule
